// ### verilog/swc_pkg.sv
// Contract
// - sleep command switches off nonessential power and nonessential clocks
// - digital core stays powered in sleep so registers and ram survive
// - sleep timer runs on low-power clock; wakes on wake time or host
// - scheduled scan or sniff events wake the chip, then sleep again
// - transports idle while asleep; wake request accepted at any time
// - wake request held during a session keeps device awake between events
// - with sleep enabled, dropping the wake request permits sleep
// - wake input asserted forces awake; deasserted allows sleep once criteria met
// - wake input polarity software selectable, active low after reset
// - host wake output asserted when host attention needed, polarity selectable
// - reference clock request asserted only while the reference is needed
// - low reset input resets the whole block, high releases it
// - in usb mode the wake input may serve as radio disable
// - in usb mode wake status uses suspend, resume and remote wake
// - radio powered only during active transmit or receive packets
// - sniff, hold and park run from low-power clock, wake after interval
package swc_pkg;

    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_WAKE_TIME = 8'h04;
    localparam logic [7:0] OFF_INTERVAL  = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0c;
    localparam logic [7:0] OFF_LPO_COUNT = 8'h10;

    // bit 0 is sleepEn, upward in declaration order reversed
    typedef struct packed {
        logic wakeTimeEn;
        logic hostAttn;
        logic radioDisEn;
        logic usbMode;
        logic hostWakeHigh;
        logic devWakeHigh;
        logic sleepEn;
    } ctrl_t;

    localparam int    CTRL_W     = $bits(ctrl_t);
    localparam ctrl_t CTRL_RESET = '0;

    typedef enum logic [2:0] {
        ST_AWAKE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_EVENT = 3'b100
    } pstate_t;

    typedef struct packed {
        logic pwrEn;
        logic clkEn;
        logic lpoSel;
        logic transportIdle;
        logic refClkReq;
    } pwr_t;

    localparam pwr_t PWR_RESET = 5'h1b;

    typedef struct packed {
        logic [2:0] state;
        logic       wakeReq;
        logic       hostAttn;
        logic       radioOn;
        logic       radioDis;
        logic       remoteWake;
    } status_t;

endpackage

// ### verilog/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int W = 1
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;
endmodule

// ### verilog/sleep_wake_controller.sv
`timescale 1ns/1ps
module sleep_wake_controller
    import swc_pkg::*;
#(
    parameter int TIMER_W = 16
)(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [REG_DATA_W-1:0] regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [REG_DATA_W-1:0] regRdata,
    input  wire logic                  devWakePin,
    input  wire logic                  lpoClkPin,
    input  wire logic                  sessionActive,
    input  wire logic                  lowPowerConn,
    input  wire logic                  eventDone,
    input  wire logic                  coreIdle,
    input  wire logic                  hostAttnReq,
    input  wire logic                  txActive,
    input  wire logic                  rxActive,
    input  wire logic                  usbSuspended,
    output pwr_t                       pwrCtl,
    output logic                       coreRetain,
    output logic                       hostWakePin,
    output logic                       radioOn,
    output logic                       radioDisable,
    output logic                       usbRemoteWake
);

    function automatic logic isAsserted(input logic level, input logic activeHigh);
        isAsserted = level ~^ activeHigh;
    endfunction

    function automatic pwr_t pwrDecode(input pstate_t s);
        pwr_t p;
        p = PWR_RESET;
        unique case (s)
            ST_AWAKE: p = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            ST_SLEEP: p = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            ST_EVENT: p = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
            default:  p = PWR_RESET;
        endcase
        pwrDecode = p;
    endfunction

    ctrl_t               ctrl_r;
    pstate_t             state_r;
    pstate_t             state_nxt;
    pwr_t                pwr_r;
    logic [TIMER_W-1:0]  wakeTime_r;
    logic [TIMER_W-1:0]  interval_r;
    logic [TIMER_W-1:0]  lpoCount_r;
    logic [TIMER_W-1:0]  evtCnt_r;
    logic                lpoPrev_r;
    logic                coreRetain_r;
    logic                hostWake_r;
    logic                radioOn_r;
    logic                radioDis_r;
    logic                remoteWake_r;
    logic [REG_DATA_W-1:0] rdata_r;
    logic [1:0]          syncQ;
    logic                lpoTick;
    logic                wakeLevel;
    logic                wakeReq;
    logic                wakeHit;
    logic                schedOn;
    logic                eventDue;
    logic                hostAttn;
    logic                hostHigh;
    logic                pktActive;
    status_t             statusWord;

    // two-flop input sync
    // the oscillator pin rides the same path; its rising edges become ticks
    sync_two_ff #(
        .W (2)
    ) u_sync (
        .clk  (mclk),
        .rstn (rstn),
        .d    ({lpoClkPin, devWakePin}),
        .q    (syncQ)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lpoPrev_r <= 1'b0;
        end else begin
            lpoPrev_r <= syncQ[1];
        end
    end

    assign lpoTick = syncQ[1] & ~lpoPrev_r;

    assign wakeLevel = isAsserted(syncQ[0], ctrl_r.devWakeHigh);

    // pin as radio disable
    // in radio disable use the pin no longer demands wake
    // host holds the line
    assign wakeReq = wakeLevel & ~(ctrl_r.usbMode & ctrl_r.radioDisEn);

    assign hostAttn  = hostAttnReq | ctrl_r.hostAttn;
    assign hostHigh  = ctrl_r.hostWakeHigh;
    assign pktActive = txActive | rxActive;
    assign schedOn   = sessionActive | lowPowerConn;

    assign wakeHit = ctrl_r.wakeTimeEn & lpoTick & (lpoCount_r == wakeTime_r);

    assign eventDue = schedOn & lpoTick & (evtCnt_r == '0);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lpoCount_r <= '0;
        end else if (lpoTick) begin
            lpoCount_r <= lpoCount_r + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            evtCnt_r <= '0;
        end else if (!schedOn) begin
            evtCnt_r <= interval_r;
        end else if (lpoTick) begin
            evtCnt_r <= (evtCnt_r == '0) ? interval_r : evtCnt_r - 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_AWAKE: begin
                if (ctrl_r.sleepEn && !wakeReq && coreIdle) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeReq || wakeHit || !ctrl_r.sleepEn) begin
                    state_nxt = ST_AWAKE;
                end else if (eventDue) begin
                    state_nxt = ST_EVENT;
                end
            end
            ST_EVENT: begin
                if (wakeReq || !ctrl_r.sleepEn) begin
                    state_nxt = ST_AWAKE;
                end else if (eventDone) begin
                    state_nxt = ST_SLEEP;
                end
            end
            default: state_nxt = ST_AWAKE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_AWAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // gate power and clocks
    // decoded from the next state so the strobes line up with state_r
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pwr_r <= PWR_RESET;
        end else begin
            pwr_r <= pwrDecode(state_nxt);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            coreRetain_r <= 1'b1;
        end else begin
            coreRetain_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostWake_r <= 1'b1;
        end else if (ctrl_r.usbMode) begin
            hostWake_r <= ~hostHigh;
        end else begin
            hostWake_r <= isAsserted(hostAttn, hostHigh);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            remoteWake_r <= 1'b0;
        end else begin
            remoteWake_r <= ctrl_r.usbMode & usbSuspended & hostAttn;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            radioDis_r <= 1'b0;
        end else begin
            radioDis_r <= ctrl_r.usbMode & ctrl_r.radioDisEn & wakeLevel;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            radioOn_r <= 1'b0;
        end else begin
            radioOn_r <= pktActive & (state_r != ST_SLEEP);
        end
    end

    // register writes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r     <= CTRL_RESET;
            wakeTime_r <= '0;
            interval_r <= '0;
        end else if (regWr) begin
            if (regAddr == OFF_CTRL) begin
                ctrl_r <= ctrl_t'(regWdata[CTRL_W-1:0]);
            end
            if (regAddr == OFF_WAKE_TIME) begin
                wakeTime_r <= regWdata[TIMER_W-1:0];
            end
            if (regAddr == OFF_INTERVAL) begin
                interval_r <= regWdata[TIMER_W-1:0];
            end
        end
    end

    assign statusWord = '{state_r, wakeReq, hostAttn, radioOn_r, radioDis_r, remoteWake_r};

    // unmapped reads answer zero; data only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (regRd) begin
                unique case (regAddr)
                    OFF_CTRL:      rdata_r <= REG_DATA_W'(ctrl_r);
                    OFF_WAKE_TIME: rdata_r <= REG_DATA_W'(wakeTime_r);
                    OFF_INTERVAL:  rdata_r <= REG_DATA_W'(interval_r);
                    OFF_STATUS:    rdata_r <= REG_DATA_W'(statusWord);
                    OFF_LPO_COUNT: rdata_r <= REG_DATA_W'(lpoCount_r);
                    default:       rdata_r <= '0;
                endcase
            end
        end
    end

    assign regRdata      = rdata_r;
    assign pwrCtl        = pwr_r;
    assign coreRetain    = coreRetain_r;
    assign hostWakePin   = hostWake_r;
    assign radioOn       = radioOn_r;
    assign radioDisable  = radioDis_r;
    assign usbRemoteWake = remoteWake_r;

    a_sleep_gates_power: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r == ST_SLEEP |-> !pwr_r.pwrEn && !pwr_r.clkEn && pwr_r.lpoSel)
        else $error("power or clock left on in sleep");

    a_core_retained: assert property (
        @(posedge mclk) disable iff (!rstn)
        $changed(state_r) |-> coreRetain_r)
        else $error("core power dropped");

    a_wake_on_request: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r == ST_SLEEP && (wakeReq || wakeHit) |=> state_r == ST_AWAKE)
        else $error("no wake from sleep");

    a_event_entry: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r == ST_SLEEP && eventDue && !wakeReq && !wakeHit && ctrl_r.sleepEn
        |=> state_r == ST_EVENT)
        else $error("scheduled event missed");

    a_event_cycle: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r == ST_EVENT && eventDone && !wakeReq && ctrl_r.sleepEn
        |=> state_r == ST_SLEEP)
        else $error("event did not return to sleep");

    a_idle_transport: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r != ST_AWAKE |-> pwr_r.transportIdle)
        else $error("transport active while asleep");

    a_stay_awake: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r != ST_SLEEP && wakeReq |=> state_r == ST_AWAKE)
        else $error("slept while wake held");

    a_withdraw_sleeps: assert property (
        @(posedge mclk) disable iff (!rstn)
        state_r == ST_AWAKE && ctrl_r.sleepEn && !wakeReq && coreIdle
        |=> state_r == ST_SLEEP)
        else $error("no sleep after withdrawal");

    a_host_wake_level: assert property (
        @(posedge mclk) disable iff (!rstn)
        !ctrl_r.usbMode && hostAttn |=> hostWake_r == $past(hostHigh))
        else $error("host wake level wrong");

    a_usb_pin_quiet: assert property (
        @(posedge mclk) disable iff (!rstn)
        ctrl_r.usbMode |=> hostWake_r == !$past(hostHigh))
        else $error("host wake pin active in usb mode");

    a_refclk_request: assert property (
        @(posedge mclk) disable iff (!rstn)
        pwr_r.refClkReq == (state_r != ST_SLEEP))
        else $error("clock request mismatch");

    a_radio_gate: assert property (
        @(posedge mclk) disable iff (!rstn)
        radioOn_r |-> $past(pktActive))
        else $error("radio on without packet");

endmodule

// ### testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic wantDev,
    input  wire logic devWakeHigh,
    input  wire logic hostWakeHigh,
    input  wire logic hostWakePin,
    output logic      devWakePin,
    output logic      hostAwake
);
    // hold wake line while device needed
    assign devWakePin = wantDev ? devWakeHigh : ~devWakeHigh;
    // host awake while host wake asserted
    assign hostAwake  = (hostWakePin == hostWakeHigh);
endmodule

// ### testbench/tb_sleep_wake_controller.sv
`timescale 1ns/1ps
module tb_sleep_wake_controller;
    import swc_pkg::*;
    logic        mclk, rstn, regWr, regRd, sessionActive, lowPowerConn, eventDone;
    logic        coreIdle, hostAttnReq, txActive, rxActive, usbSuspended, coreRetain;
    logic        hostWakePin, radioOn, radioDisable, usbRemoteWake, devWakePin, hostAwake;
    logic        wantDev, devPol, hostPol;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, rdData;
    logic [2:0]  lpoDiv    = 3'h0;
    logic        lpoClkPin = 1'b0;
    pwr_t        pwrCtl;
    int          err_total, samples_checked;

    sleep_wake_controller #(.TIMER_W(16)) i_dut (
        .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .devWakePin(devWakePin), .lpoClkPin(lpoClkPin),
        .sessionActive(sessionActive), .lowPowerConn(lowPowerConn), .eventDone(eventDone),
        .coreIdle(coreIdle), .hostAttnReq(hostAttnReq), .txActive(txActive),
        .rxActive(rxActive), .usbSuspended(usbSuspended), .pwrCtl(pwrCtl),
        .coreRetain(coreRetain), .hostWakePin(hostWakePin), .radioOn(radioOn),
        .radioDisable(radioDisable), .usbRemoteWake(usbRemoteWake));

    host_model i_host (.wantDev(wantDev), .devWakeHigh(devPol), .hostWakeHigh(hostPol),
        .hostWakePin(hostWakePin), .devWakePin(devWakePin), .hostAwake(hostAwake));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // slow tick source, sampled as data by the block
    always @(posedge mclk) begin
        lpoDiv    <= lpoDiv + 3'h1;
        lpoClkPin <= lpoDiv[2];
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1 rdData = regRdata;
    endtask

    // polls status; a spent bound is counted and ends the run
    task automatic wait_state(input logic [2:0] s);
        int i;
        for (i = 0; i < 300; i++) begin
            rd(OFF_STATUS);
            if (rdData[7:5] === s) break;
        end
        chk("state", {29'h0, s}, {29'h0, rdData[7:5]});
        if (i == 300) print_verdict();
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic reset_values();
        chk("pwrCtl awake", 32'h19, {27'h0, pwrCtl});
        chk("coreRetain", 32'h1, {31'h0, coreRetain});
        rd(OFF_CTRL);
        chk("ctrl reset", 32'h0, rdData);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14);
        chk("unmapped", 32'h0, rdData);
    endtask

    task automatic sleep_and_pin_wake();
        wr(OFF_CTRL, 32'h1);
        wait_state(3'b010);
        chk("pwrCtl sleep", 32'h06, {27'h0, pwrCtl});
        chk("retain in sleep", 32'h1, {31'h0, coreRetain});
        @(posedge mclk) wantDev <= 1'b1;
        settle(3);
        chk("pwrCtl woken", 32'h19, {27'h0, pwrCtl});
        @(posedge mclk) wantDev <= 1'b0;
        wait_state(3'b010);
        wr(OFF_CTRL, 32'h3);
        @(posedge mclk) devPol <= 1'b1;
        wait_state(3'b010);
        @(posedge mclk) wantDev <= 1'b1;
        wait_state(3'b001);
        @(posedge mclk) wantDev <= 1'b0;
        wait_state(3'b010);
    endtask

    task automatic scheduled_event();
        wr(OFF_INTERVAL, 32'h2);
        @(posedge mclk) sessionActive <= 1'b1;
        wait_state(3'b100);
        chk("pwrCtl event", 32'h1b, {27'h0, pwrCtl});
        @(posedge mclk) eventDone <= 1'b1;
        @(posedge mclk) eventDone <= 1'b0;
        wait_state(3'b010);
        @(posedge mclk) begin
            sessionActive <= 1'b0;
            lowPowerConn  <= 1'b1;
        end
        wait_state(3'b100);
        @(posedge mclk) eventDone <= 1'b1;
        @(posedge mclk) eventDone <= 1'b0;
        wait_state(3'b010);
        @(posedge mclk) wantDev <= 1'b1;
        wait_state(3'b001);
        settle(120);
        rd(OFF_STATUS);
        chk("awake in session", 32'h1, {29'h0, rdData[7:5]});
        @(posedge mclk) wantDev <= 1'b0;
        lowPowerConn <= 1'b0;
        wait_state(3'b010);
    endtask

    task automatic timed_wake();
        rd(OFF_LPO_COUNT);
        wr(OFF_WAKE_TIME, rdData + 32'h6);
        @(posedge mclk) coreIdle <= 1'b0;
        wr(OFF_CTRL, 32'h43);
        wait_state(3'b001);
        @(posedge mclk) coreIdle <= 1'b1;
    endtask

    task automatic host_side();
        wr(OFF_CTRL, 32'h2);
        @(posedge mclk) hostAttnReq <= 1'b1;
        txActive <= 1'b1;
        settle(2);
        chk("hostWake low", 32'h0, {31'h0, hostWakePin});
        chk("host awake", 32'h1, {31'h0, hostAwake});
        chk("radioOn", 32'h1, {31'h0, radioOn});
        wr(OFF_CTRL, 32'h6);
        @(posedge mclk) hostPol <= 1'b1;
        settle(2);
        chk("hostWake high", 32'h1, {31'h0, hostWakePin});
        @(posedge mclk) txActive <= 1'b0;
        settle(2);
        chk("radio off", 32'h0, {31'h0, radioOn});
        @(posedge mclk) usbSuspended <= 1'b1;
        wr(OFF_CTRL, 32'h1e);
        settle(2);
        chk("remote wake", 32'h1, {31'h0, usbRemoteWake});
        chk("pin held off", 32'h0, {31'h0, hostWakePin});
        chk("radio enable", 32'h0, {31'h0, radioDisable});
        @(posedge mclk) wantDev <= 1'b1;
        settle(4);
        chk("radio disable", 32'h1, {31'h0, radioDisable});
    endtask

    initial begin
        {regWr, regRd, sessionActive, lowPowerConn, eventDone} = '0;
        {hostAttnReq, txActive, rxActive, usbSuspended, wantDev, devPol, hostPol} = '0;
        coreIdle        = 1'b1;
        regAddr         = 8'h0;
        regWdata        = 32'h0;
        err_total       = 0;
        samples_checked = 0;
        rstn            = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        settle(4);
        reset_values();
        sleep_and_pin_wake();
        scheduled_event();
        timed_wake();
        host_side();
        print_verdict();
    end
endmodule
